/* rtl/sai_rx.sv */
// serial audio input receiver with clock-crossing word fifo
`timescale 1ns/10ps
`default_nettype none

module sai_fifo #(
   parameter int W     = 31,
   parameter int DEPTH = 32
) (
   // write side
   input  wire logic         wclk,
   input  wire logic         wrst,
   input  wire logic         w_valid,
   input  wire logic [W-1:0] w_data,
   output logic              w_ready,
   // read side
   input  wire logic         rclk,
   input  wire logic         rrst,
   output logic              r_valid,
   output logic [W-1:0]      r_data,
   input  wire logic         r_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wbin_r;
   logic [AW:0]  wgray_r;
   logic [AW:0]  rq1_r;
   logic [AW:0]  rq2_r;
   logic [AW:0]  rbin_r;
   logic [AW:0]  rgray_r;
   logic [AW:0]  wq1_r;
   logic [AW:0]  wq2_r;
   logic         full;
   logic         empty;
   logic         rd_take;
   logic [AW:0]  wbin_nxt;
   logic [AW:0]  rbin_nxt;

   //------------------------------------------------------------------
   // write domain
   //------------------------------------------------------------------
   assign full     = wgray_r == {~rq2_r[AW:AW-1], rq2_r[AW-2:0]};
   assign w_ready  = ~full;
   assign wbin_nxt = wbin_r + 1'b1;

   always_ff @(posedge wclk) begin
      rq1_r <= rgray_r;
      rq2_r <= rq1_r;
      if (w_valid && !full) begin
         mem[wbin_r[AW-1:0]] <= w_data;
      end
      if (wrst) begin
         wbin_r  <= '0;
         wgray_r <= '0;
      end else if (w_valid && !full) begin
         wbin_r  <= wbin_nxt;
         wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
      end
   end

   //------------------------------------------------------------------
   // read domain: output register loads when empty or drained
   //------------------------------------------------------------------
   assign empty    = rgray_r == wq2_r;
   assign rd_take  = !empty && (!r_valid || r_ready);
   assign rbin_nxt = rbin_r + 1'b1;

   always_ff @(posedge rclk) begin
      wq1_r <= wgray_r;
      wq2_r <= wq1_r;
      if (rrst) begin
         rbin_r  <= '0;
         rgray_r <= '0;
         r_valid <= 1'b0;
         r_data  <= '0;
      end else if (rd_take) begin
         rbin_r  <= rbin_nxt;
         rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
         r_valid <= 1'b1;
         r_data  <= mem[rbin_r[AW-1:0]];
      end else if (r_ready) begin
         r_valid <= 1'b0;
      end
   end
endmodule

module sai_rx
   import sai_pkg::*;
(
   // system clock and reset
   input  wire logic              clk,
   input  wire logic              srst,
   // control register port
   input  wire logic              reg_wr_en,
   input  wire logic [11:0]       reg_addr,
   input  wire logic [7:0]        reg_wdata,
   output logic [7:0]             reg_rdata,
   // serial audio link
   input  wire logic              bit_clk,
   input  wire logic              word_clk,
   input  wire logic              serial_in_lane0,
   // received words toward the core
   output logic                   out_valid,
   output logic [2:0]             out_slot,
   output logic [SAI_CORE_BITS-1:0] out_sample,
   input  wire logic              out_ready
);

   //------------------------------------------------------------------
   // system domain state
   //------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] rdata;
   } sai_sys_t;

   sai_sys_t sys_r;
   sai_sys_t sys_nxt;

   always_comb begin
      sys_nxt = sys_r;
      sys_nxt.rdata = (reg_addr == SAI_CTRL_ADDR) ? sys_r.ctrl : 8'h00;
      if (reg_wr_en && reg_addr == SAI_CTRL_ADDR) begin
         sys_nxt.ctrl = reg_wdata & SAI_CTRL_WMASK;
      end
      if (srst) begin
         sys_nxt.ctrl  = SAI_CTRL_RESET;
         sys_nxt.rdata = 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      sys_r <= sys_nxt;
   end

   assign reg_rdata = sys_r.rdata;

   //------------------------------------------------------------------
   // link domain
   //------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  ctl_s1;
      logic [7:0]  ctl_s2;
      logic [7:0]  ctl_s3;
      logic [7:0]  ctl;
      logic        rst_s1;
      logic        rst_s2;
      logic        lr_q;
      logic [4:0]  bitpos;
      logic [23:0] shreg;
      logic [4:0]  cnt;
      logic [2:0]  chan;
      logic        armed;
      logic        wv;
      sai_word_t   wd;
   } sai_link_t;

   sai_link_t lk_r;
   sai_link_t lk_nxt;
   logic [1:0] neg_q_r;
   logic       fifo_ready;

   // falling-edge capture, used when data changes on the rising edge
   always_ff @(negedge bit_clk) begin
      neg_q_r <= {word_clk, serial_in_lane0};
   end

   function automatic logic [SAI_CORE_BITS-1:0] sext(input logic [23:0] w);
      sext = {{(SAI_CORE_BITS - SAI_IN_BITS){w[23]}}, w};
   endfunction

   always_comb begin
      logic        wpol;
      logic        edge_sel;
      logic [2:0]  fmt;
      logic        is_tdm;
      logic        lr;
      logic        din;
      logic        frame_edge;
      logic        boundary;
      logic [23:0] word;
      logic [4:0]  pad;
      lk_nxt     = lk_r;
      wpol       = lk_r.ctl[SAI_WCLK_POL_BIT];
      edge_sel   = lk_r.ctl[SAI_BCLK_EDGE_BIT];
      fmt        = lk_r.ctl[SAI_FMT_LSB +: 3];
      is_tdm     = fmt == SAI_FMT_TDM;
      lr         = edge_sel ? neg_q_r[1] : word_clk;
      din        = edge_sel ? neg_q_r[0] : serial_in_lane0;
      // trigger edge, pulse first edge, start on the edge into the wpol level
      frame_edge = (lr != lk_r.lr_q) && (lr == wpol);
      boundary   = is_tdm ? (frame_edge || lk_r.bitpos == SAI_SLOT_LAST)
                          : (lr != lk_r.lr_q);
      pad        = SAI_IN_BITS_C - lk_r.cnt;
      word       = lk_r.shreg << pad;
      unique case (fmt)
         SAI_FMT_RJ24: word = lk_r.shreg;
         SAI_FMT_RJ20: word = {{4{lk_r.shreg[19]}}, lk_r.shreg[19:0]};
         SAI_FMT_RJ18: word = {{6{lk_r.shreg[17]}}, lk_r.shreg[17:0]};
         SAI_FMT_RJ16: word = {{8{lk_r.shreg[15]}}, lk_r.shreg[15:0]};
         default:      word = lk_r.shreg << pad;
      endcase

      lk_nxt.ctl_s1 = sys_r.ctrl;
      lk_nxt.ctl_s2 = lk_r.ctl_s1;
      lk_nxt.ctl_s3 = lk_r.ctl_s2;
      // the byte crosses bit by bit: only a value seen twice in a row is settled
      if (lk_r.ctl_s2 == lk_r.ctl_s3) begin
         lk_nxt.ctl = lk_r.ctl_s2;
      end
      lk_nxt.rst_s1 = srst;
      lk_nxt.rst_s2 = lk_r.rst_s1;
      lk_nxt.lr_q   = lr;
      lk_nxt.bitpos = boundary ? 5'h00 : lk_r.bitpos + 5'h01;
      if (lk_r.wv && fifo_ready) begin
         lk_nxt.wv = 1'b0;
      end

      if (boundary) begin
         if (lk_r.armed) begin
            lk_nxt.wv        = 1'b1;
            lk_nxt.wd.sample = sext(word);
            // channel from word-clock level, tdm slot number
            lk_nxt.wd.slot   = is_tdm ? lk_r.chan : {2'b00, lk_r.lr_q ^ wpol};
         end
         if (is_tdm) begin
            // eight slots then wait for next frame
            lk_nxt.chan  = frame_edge ? 3'h0 : lk_r.chan + 3'h1;
            lk_nxt.armed = frame_edge || (lk_r.armed && lk_r.chan != SAI_SLOT_MAX);
         end else begin
            lk_nxt.chan  = 3'h0;
            lk_nxt.armed = 1'b1;
         end
         // i2s and tdm skip the delay bit, left-justified keeps it
         if (fmt == SAI_FMT_LJ) begin
            lk_nxt.shreg = {23'h00_0000, din};
            lk_nxt.cnt   = 5'h01;
         end else begin
            lk_nxt.shreg = (fmt >= SAI_FMT_RJ24) ? {lk_r.shreg[22:0], din} : 24'h00_0000;
            lk_nxt.cnt   = 5'h00;
         end
      end else if (fmt >= SAI_FMT_RJ24 || lk_r.cnt < SAI_IN_BITS_C) begin
         // right-justified keeps the newest bits, others keep the first 24
         lk_nxt.shreg = {lk_r.shreg[22:0], din};
         lk_nxt.cnt   = (lk_r.cnt < SAI_IN_BITS_C) ? lk_r.cnt + 5'h01 : lk_r.cnt;
      end

      if (fmt == SAI_FMT_RSVD) begin
         lk_nxt.armed = 1'b0;
         lk_nxt.wv    = lk_r.wv && !fifo_ready;
      end

      if (lk_r.rst_s2) begin
         lk_nxt.lr_q   = 1'b0;
         lk_nxt.bitpos = 5'h00;
         lk_nxt.shreg  = 24'h00_0000;
         lk_nxt.cnt    = 5'h00;
         lk_nxt.chan   = 3'h0;
         lk_nxt.armed  = 1'b0;
         lk_nxt.wv     = 1'b0;
         lk_nxt.wd     = '0;
      end
   end

   always_ff @(posedge bit_clk) begin
      lk_r <= lk_nxt;
   end

   //------------------------------------------------------------------
   // word crossing into the system domain
   //------------------------------------------------------------------
   sai_word_t rd_word;

   sai_fifo #(
      .W     (SAI_WORD_W),
      .DEPTH (SAI_FIFO_DEPTH)
   ) u_fifo (
      .wclk    (bit_clk),
      .wrst    (lk_r.rst_s2),
      .w_valid (lk_r.wv),
      .w_data  (lk_r.wd),
      .w_ready (fifo_ready),
      .rclk    (clk),
      .rrst    (srst),
      .r_valid (out_valid),
      .r_data  (rd_word),
      .r_ready (out_ready)
   );

   assign out_slot   = rd_word.slot;
   assign out_sample = rd_word.sample;

endmodule

`default_nettype wire

/* rtl/sai_pkg.sv */
// constants and carrier types for the serial audio input port
//------------------------------------------------------------------
// Operation
// - polarity bit 0: left while word clock low
// - tdm frame starts after selected word-clock edge
// - pulse word clock: first edge starts frame
// - three-bit field selects the frame format
// - tdm slot msb one bit after boundary
// - eight tdm slots, four per frame half
// - rising frame start, falling data change supported
// - twos complement msb first, left before right
// - words up to 24 bits, sign-extended to 28
//------------------------------------------------------------------
package sai_pkg;

   // register map
   localparam logic [11:0] SAI_CTRL_ADDR      = 12'h081f;
   localparam logic [7:0]  SAI_CTRL_RESET     = 8'h00;
   localparam logic [7:0]  SAI_CTRL_WMASK     = 8'h1f;
   localparam int          SAI_WCLK_POL_BIT   = 4;
   localparam int          SAI_BCLK_EDGE_BIT  = 3;
   localparam int          SAI_FMT_LSB        = 0;

   // format codes
   localparam logic [2:0] SAI_FMT_I2S   = 3'h0;
   localparam logic [2:0] SAI_FMT_LJ    = 3'h1;
   localparam logic [2:0] SAI_FMT_TDM   = 3'h2;
   localparam logic [2:0] SAI_FMT_RJ24  = 3'h3;
   localparam logic [2:0] SAI_FMT_RJ20  = 3'h4;
   localparam logic [2:0] SAI_FMT_RJ18  = 3'h5;
   localparam logic [2:0] SAI_FMT_RJ16  = 3'h6;
   localparam logic [2:0] SAI_FMT_RSVD  = 3'h7;

   // word and frame geometry
   localparam int          SAI_IN_BITS    = 24;
   localparam int          SAI_CORE_BITS  = 28;
   localparam logic [4:0]  SAI_IN_BITS_C  = 5'h18;
   localparam logic [4:0]  SAI_SLOT_LAST  = 5'h1f;
   localparam logic [2:0]  SAI_SLOT_MAX   = 3'h7;
   localparam int          SAI_FIFO_DEPTH = 32;

   typedef struct packed {
      logic [2:0]               slot;
      logic [SAI_CORE_BITS-1:0] sample;
   } sai_word_t;

   localparam int SAI_WORD_W = $bits(sai_word_t);

endpackage

/* verification/sai_src.sv */
// partner model: external converter driving the serial link
`timescale 1ns/10ps
`default_nettype none
module sai_src (
   // serial link toward the receiver
   output logic      bit_clk,
   output logic      word_clk,
   output logic      serial_in_lane0,
   // 1: change data on rising bit clock
   input  wire logic chg_rise
);
   // free-running: receiver needs link edges in reset and config
   initial begin
      bit_clk = 1'b0;
      word_clk = 1'b1;
      serial_in_lane0 = 1'b0;
      #3;
      forever #16 bit_clk = ~bit_clk;
   end
   task automatic slot(input logic wc0, input logic wc, input logic [23:0] d, input int dly);
      for (int i = 0; i < 32; i++) begin
         if (chg_rise)
            @(posedge bit_clk);
         else
            @(negedge bit_clk);
         word_clk <= (i == 0) ? wc0 : wc;
         // idle bits toggle so a stale level never passes for data
         serial_in_lane0 <= (i >= dly && i < dly + 24) ? d[23 + dly - i] : ~serial_in_lane0;
      end
   endtask
endmodule
`default_nettype wire

/* verification/sai_rx_properties.sv */
// checker for the receiver's register and output ports
`timescale 1ns/10ps
`default_nettype none
module sai_rx_properties
   import sai_pkg::*;
(
   // clock and reset
   input wire logic                     clk,
   input wire logic                     srst,
   // register port
   input wire logic                     reg_wr_en,
   input wire logic [11:0]              reg_addr,
   input wire logic [7:0]               reg_wdata,
   input wire logic [7:0]               reg_rdata,
   // output stream
   input wire logic                     out_valid,
   input wire logic [2:0]               out_slot,
   input wire logic [SAI_CORE_BITS-1:0] out_sample,
   input wire logic                     out_ready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   AST_RSVD_ZERO: assert property (reg_rdata[7:5] == 3'h0) else $error("reserved bits set");
   AST_UNMAPPED: assert property (reg_addr != SAI_CTRL_ADDR |=> reg_rdata == 8'h00)
      else $error("unmapped read nonzero");
   AST_READBACK: assert property ((reg_wr_en && reg_addr == SAI_CTRL_ADDR)
      ##1 (!reg_wr_en && reg_addr == SAI_CTRL_ADDR)
      |=> reg_rdata == ($past(reg_wdata, 2) & SAI_CTRL_WMASK)) else $error("bad readback");
   AST_STABLE: assert property ((!reg_wr_en && reg_addr == SAI_CTRL_ADDR)[*3]
      |=> $stable(reg_rdata)) else $error("control changed unwritten");
   AST_RESET_OUT: assert property ($fell(srst) |-> !out_valid && reg_rdata == 8'h00)
      else $error("outputs not cleared by reset");
   AST_VALID_HOLD: assert property (out_valid && !out_ready |=> out_valid)
      else $error("word withdrawn");
   AST_DATA_HOLD: assert property (out_valid && !out_ready
      |=> $stable(out_sample) && $stable(out_slot)) else $error("word changed while held");
   AST_SIGN_EXT: assert property (out_valid |-> out_sample[27:24] == {4{out_sample[23]}})
      else $error("sample not sign-extended");
   AST_VALID_FALL: assert property ($fell(out_valid) |-> $past(out_ready))
      else $error("valid dropped without accept");
endmodule
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the serial audio input port
`timescale 1ns/10ps
`default_nettype none
module tb
   import sai_pkg::*;
;
   logic clk = 1'b0, srst = 1'b1, reg_wr_en = 1'b0, chg_rise = 1'b0, out_ready = 1'b1;
   logic [11:0] reg_addr = 12'h0000;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   logic bit_clk, word_clk, serial_in_lane0, out_valid;
   logic [2:0] out_slot;
   logic [SAI_CORE_BITS-1:0] out_sample;
   sai_word_t q[$], ex[$];
   int errors = 0, n_tests = 0, cyc = 0;
   always #25 clk = ~clk;
   sai_rx i_sai_rx (.clk, .srst, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata, .bit_clk,
      .word_clk, .serial_in_lane0, .out_valid, .out_slot, .out_sample, .out_ready);
   sai_src i_sai_src (.bit_clk, .word_clk, .serial_in_lane0, .chg_rise);
   always @(posedge clk) begin
      if (out_valid === 1'b1 && out_ready === 1'b1)
         q.push_back({out_slot, out_sample});
      cyc++;
      // hang guard, well above the run's length
      if (cyc == 40000) begin
         errors++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [SAI_WORD_W-1:0] e, g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic sai_word_t wd(input logic [2:0] s, input logic [7:0] k);
      return {s, {4{k[7]}}, k, ~k, k};
   endfunction
   // newest n bits of the 24-bit pattern as a twos complement word, sign-extended
   function automatic sai_word_t wdn(input logic [2:0] s, input logic [7:0] k, input int n);
      logic signed [SAI_CORE_BITS-1:0] v;
      v = SAI_CORE_BITS'({k, ~k, k}) << (SAI_CORE_BITS - n);
      v = v >>> (SAI_CORE_BITS - n);
      return {s, v};
   endfunction
   task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr_en = 1'b0;
   endtask
   task automatic reg_rd(input logic [11:0] a, input logic [7:0] e);
      @(negedge clk);
      reg_addr = a;
      @(negedge clk);
      chk("reg_rdata", {23'h0, e}, {23'h0, reg_rdata});
   endtask
   task automatic cfg(input logic pol, input logic ce, input logic [2:0] f);
      reg_wr(SAI_CTRL_ADDR, {3'h0, pol, ce, f});
      chg_rise = ce;
      repeat (8) @(posedge bit_clk);
      q.delete();
   endtask
   task automatic ch(input logic lvl, input int dly, input logic [7:0] k);
      i_sai_src.slot(lvl, lvl, {k, ~k, k}, dly);
   endtask
   // only the newest words count: earlier ones may be dropped while arming
   task automatic tail();
      int b;
      b = q.size() - ex.size();
      chk("words", 31'(ex.size()), 31'(b < 0 ? 0 : ex.size()));
      if (b >= 0)
         foreach (ex[i])
            chk("word", ex[i], q[b + i]);
   endtask
   task automatic t2(input logic pol, input logic [2:0] f, input int dly, input int n);
      cfg(pol, 1'b0, f);
      ch(~pol, dly, 8'h11);
      ch(pol, dly, 8'h93);
      ch(~pol, dly, 8'h5a);
      ch(pol, dly, 8'h22);
      repeat (20) @(negedge clk);
      ex = {wdn(3'h0, 8'h93, n), wdn(3'h1, 8'h5a, n)};
      tail();
      $display("test two-channel %0d done", f);
   endtask
   task automatic frame(input logic pol, input logic [7:0] b);
      logic [7:0] k;
      for (int s = 0; s < 8; s++) begin
         k = b + 8'(s);
         // stream on lane zero, msb one bit late
         i_sai_src.slot(s == 0 ? pol : ~pol, ~pol, {k, ~k, k}, 1);
      end
   endtask
   task automatic t_tdm(input logic pol, input logic ce);
      cfg(pol, ce, SAI_FMT_TDM);
      frame(pol, 8'h10);
      frame(pol, 8'h80);
      repeat (20) @(negedge clk);
      ex = {};
      for (int s = 0; s < 8; s++)
         ex.push_back(wd(3'(s), 8'h80 + 8'(s)));
      tail();
      $display("test tdm done");
   endtask
   task automatic t_rsvd();
      cfg(1'b0, 1'b0, SAI_FMT_RSVD);
      ch(1'b1, 1, 8'h01);
      q.delete();
      ch(1'b0, 1, 8'h02);
      ch(1'b1, 1, 8'h03);
      ch(1'b0, 1, 8'h04);
      repeat (20) @(negedge clk);
      chk("words", 31'h0, 31'(q.size()));
      $display("test reserved done");
   endtask
   task automatic t_fifo();
      cfg(1'b0, 1'b0, SAI_FMT_TDM);
      frame(1'b0, 8'h00);
      repeat (20) @(negedge clk);
      out_ready = 1'b0;
      q.delete();
      for (int f = 1; f < 6; f++)
         frame(1'b0, 8'(f * 8));
      @(negedge clk);
      out_ready = 1'b1;
      repeat (60) @(negedge clk);
      // output register, 32 queued words, then the newest word held at the link
      chk("words", 31'd34, 31'(q.size()));
      if (q.size() == 34) begin
         chk("first", wd(3'h0, 8'h08), q[0]);
         chk("queued", wd(3'h0, 8'h28), q[32]);
         chk("last", wd(3'h7, 8'h2f), q[33]);
      end
      $display("test fifo done");
   endtask
   initial begin
      repeat (6) @(negedge clk);
      srst = 1'b0;
      reg_rd(SAI_CTRL_ADDR, 8'h00);
      reg_wr(SAI_CTRL_ADDR, 8'hff);
      reg_rd(SAI_CTRL_ADDR, 8'h1f);
      reg_wr(12'h081e, 8'h0a);
      reg_rd(12'h081e, 8'h00);
      reg_rd(SAI_CTRL_ADDR, 8'h1f);
      $display("test registers done");
      t2(1'b0, SAI_FMT_I2S, 1, 24);
      t2(1'b1, SAI_FMT_I2S, 1, 24);
      t2(1'b1, SAI_FMT_LJ, 0, 24);
      t2(1'b1, SAI_FMT_RJ24, 8, 24);
      t2(1'b1, SAI_FMT_RJ20, 8, 20);
      t2(1'b1, SAI_FMT_RJ18, 8, 18);
      t2(1'b1, SAI_FMT_RJ16, 8, 16);
      t_tdm(1'b0, 1'b0);
      t_tdm(1'b1, 1'b0);
      t_tdm(1'b1, 1'b1);
      t_rsvd();
      t_fifo();
      final_report();
   end
endmodule
bind sai_rx sai_rx_properties i_sai_rx_properties (.clk(clk), .srst(srst),
   .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .out_valid(out_valid), .out_slot(out_slot), .out_sample(out_sample), .out_ready(out_ready));
`default_nettype wire
